// ### core/pist_ctrl.v
// Interrupt source block: external edge, conversion done, two time bases, serial module
//
// How it works
// - A selected edge on the external pin sets the external request flag.
// - External vector only with global and external enable, stack free, flag set.
// - Edge select gives rising, falling, both, or disables the external source.
// - Pull-high selection stays active while the pin is the interrupt input.
// - Servicing the external source clears its flag and the global enable.
// - Conversion finish sets the converter request flag.
// - Converter vectored with global and converter enable, stack free; service clears both.
// - Each time-base unit sets its own flag on divider overflow.
// - Time-base vectored with global and unit enable, stack free; service clears both.
// - Source field: 00 system clock, 01 system clock by four, 1x sub clock.
// - Period field codes 000 to 111 give 2^8 to 2^15 prescaler periods.
// - Prescaler source bits 7 to 2 read zero; fields reset to zero.
// - SPI/I2C: byte done, address match, bus time-out set the serial flag.
// - UART: tx empty, tx idle, rx data, overrun, address, wake set the flag.
// - Serial vectored with global and module enable, stack free; service clears both.
// - Servicing serial leaves UART status flags alone; only UART actions clear them.
// - Any flag rising from low to high requests wake-up, enables ignored.
// - A set flag stays set until serviced or cleared by software.
// - Return-from-interrupt sets the global enable; a plain return leaves it.
`timescale 1ns/100ps
`default_nettype none
`include "pist_regs.vh"

module pist_ctrl (
	// Clock, reset, clock enable
	input wire sys_clk,
	input wire sys_rst,
	input wire clk_en,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// External pin and its pin-sharing state
	input wire ext_irq_pin,
	input wire pin_func_sel,
	input wire port_is_input,
	input wire pullup_sel,
	output reg pull_high_en,
	// Peripheral events, one-cycle pulses, and the serial mode select level
	input wire conv_done,
	input wire sub_clk_tick,
	input wire serial_uart_mode,
	input wire spi_i2c_byte_done,
	input wire i2c_addr_match,
	input wire i2c_bus_timeout,
	input wire uart_tx_empty,
	input wire uart_tx_idle,
	input wire uart_rx_avail,
	input wire uart_rx_overrun,
	input wire uart_addr_detect,
	input wire uart_rx_wake,
	// CPU core vectoring
	input wire stack_full,
	input wire irq_ack,
	input wire return_from_irq,
	output reg irq_req,
	output reg [2:0] irq_vector,
	output reg wake_req
);

	// Software-visible state
	reg [1:0] prescaler_src_sel;
	reg tb0_run;
	reg [2:0] tb0_period_sel;
	reg tb1_run;
	reg [2:0] tb1_period_sel;
	reg [5:0] irq_enable;
	reg [4:0] irq_flag;
	reg [1:0] edge_select_reg;

	// Pin synchroniser and edge history
	reg pin_meta;
	reg pin_sync;
	reg pin_prev;

	// Prescaler
	reg [1:0] div4_count;
	reg psc_tick;

	// Time-base overflow pulses
	wire tb0_ovf;
	wire tb1_ovf;

	// Combinational next values
	reg [4:0] hw_set;
	reg [4:0] svc_clear;
	reg [4:0] next_flag;
	reg [5:0] next_enable;
	reg [4:0] pending;
	reg next_req;
	reg [2:0] next_vector;
	reg [31:0] rd_data;
	reg rd_err;
	reg ext_rise;
	reg ext_fall;
	reg ext_hit;
	reg serial_event;

	wire wr_fire;
	wire setup;

	// A write lands only at the access edge where pready is seen high
	assign wr_fire = psel & penable & pwrite & pready;
	assign setup = psel & ~penable;

	// Two-flop synchroniser, then one more stage for edge comparison
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_meta <= 1'b0;
			pin_sync <= 1'b0;
			pin_prev <= 1'b0;
		end else if (clk_en) begin
			pin_meta <= ext_irq_pin;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	// Edge qualification; the pin counts only once software has handed it to the interrupt
	always @* begin
		ext_rise = pin_sync & ~pin_prev;
		ext_fall = ~pin_sync & pin_prev;
		ext_hit = 1'b0;
		if (pin_func_sel && port_is_input) begin
			case (edge_select_reg)
				`PIST_EDGE_RISE: ext_hit = ext_rise;
				`PIST_EDGE_FALL: ext_hit = ext_fall;
				`PIST_EDGE_BOTH: ext_hit = ext_rise | ext_fall;
				default: ext_hit = 1'b0;
			endcase
		end
	end

	// Serial events; this block only observes them, UART status is cleared elsewhere
	always @* begin
		if (serial_uart_mode) begin
			serial_event = uart_tx_empty | uart_tx_idle | uart_rx_avail
				| uart_rx_overrun | uart_addr_detect | uart_rx_wake;
		end else begin
			serial_event = spi_i2c_byte_done | i2c_addr_match | i2c_bus_timeout;
		end
	end

	// Prescaler clock select: every cycle, every fourth cycle or sub clock ticks
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			div4_count <= 2'h0;
			psc_tick <= 1'b0;
		end else if (clk_en) begin
			div4_count <= div4_count + 2'h1;
			if (prescaler_src_sel[1]) begin
				psc_tick <= sub_clk_tick;
			end else if (prescaler_src_sel == `PIST_PSC_SYS_DIV4) begin
				psc_tick <= (div4_count == `PIST_DIV4_LAST);
			end else begin
				psc_tick <= 1'b1;
			end
		end
	end

	// The two time-base units share one prescaler tick
	pist_tbu u_tb0 (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.tick(psc_tick),
		.run(tb0_run),
		.period_sel(tb0_period_sel),
		.overflow(tb0_ovf)
	);

	pist_tbu u_tb1 (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.tick(psc_tick),
		.run(tb1_run),
		.period_sel(tb1_period_sel),
		.overflow(tb1_ovf)
	);

	// Flag and enable next values; a hardware set beats any clear in the same cycle
	always @* begin
		hw_set = 5'h00;
		hw_set[`PIST_SRC_EXT] = ext_hit;
		hw_set[`PIST_SRC_CONV] = conv_done;
		hw_set[`PIST_SRC_TB0] = tb0_ovf;
		hw_set[`PIST_SRC_TB1] = tb1_ovf;
		hw_set[`PIST_SRC_SER] = serial_event;
		svc_clear = 5'h00;
		if (irq_ack && irq_req) begin
			case (irq_vector)
				`PIST_VEC_EXT: svc_clear[`PIST_SRC_EXT] = 1'b1;
				`PIST_VEC_CONV: svc_clear[`PIST_SRC_CONV] = 1'b1;
				`PIST_VEC_TB0: svc_clear[`PIST_SRC_TB0] = 1'b1;
				`PIST_VEC_TB1: svc_clear[`PIST_SRC_TB1] = 1'b1;
				`PIST_VEC_SER: svc_clear[`PIST_SRC_SER] = 1'b1;
				default: svc_clear = 5'h00;
			endcase
		end
		// Flags hold until serviced or written, whatever the enables say
		next_flag = irq_flag;
		if (wr_fire && paddr == `PIST_ADDR_IFLAG) begin
			next_flag = pwdata[4:0];
		end
		next_flag = (next_flag & ~svc_clear) | hw_set;
		next_enable = irq_enable;
		if (wr_fire && paddr == `PIST_ADDR_IEN) begin
			next_enable = pwdata[5:0];
		end
		if (return_from_irq) begin
			next_enable[`PIST_IEN_GLOBAL] = 1'b1;
		end
		// Service blocks nesting until software or a return re-enables
		if (irq_ack && irq_req) begin
			next_enable[`PIST_IEN_GLOBAL] = 1'b0;
		end
	end

	// Request and vector from the next state, so a serviced source drops at once
	always @* begin
		pending[`PIST_SRC_EXT] = next_flag[`PIST_SRC_EXT] & next_enable[`PIST_IEN_EXT];
		pending[`PIST_SRC_CONV] = next_flag[`PIST_SRC_CONV] & next_enable[`PIST_IEN_CONV];
		pending[`PIST_SRC_TB0] = next_flag[`PIST_SRC_TB0] & next_enable[`PIST_IEN_TB0];
		pending[`PIST_SRC_TB1] = next_flag[`PIST_SRC_TB1] & next_enable[`PIST_IEN_TB1];
		pending[`PIST_SRC_SER] = next_flag[`PIST_SRC_SER] & next_enable[`PIST_IEN_SER];
		// A full stack holds every request back until the core pops
		next_req = next_enable[`PIST_IEN_GLOBAL] & ~stack_full & (|pending);
		// Fixed priority, external first
		if (pending[`PIST_SRC_EXT]) begin
			next_vector = `PIST_VEC_EXT;
		end else if (pending[`PIST_SRC_CONV]) begin
			next_vector = `PIST_VEC_CONV;
		end else if (pending[`PIST_SRC_TB0]) begin
			next_vector = `PIST_VEC_TB0;
		end else if (pending[`PIST_SRC_TB1]) begin
			next_vector = `PIST_VEC_TB1;
		end else if (pending[`PIST_SRC_SER]) begin
			next_vector = `PIST_VEC_SER;
		end else begin
			next_vector = irq_vector;
		end
	end

	// Register state and core-facing outputs
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_flag <= `PIST_IFLAG_RST;
			irq_enable <= `PIST_IEN_RST;
			irq_req <= 1'b0;
			irq_vector <= `PIST_VEC_EXT;
			wake_req <= 1'b0;
			pull_high_en <= 1'b0;
		end else if (clk_en) begin
			irq_flag <= next_flag;
			irq_enable <= next_enable;
			irq_req <= next_req;
			irq_vector <= next_vector;
			// Any rising flag wakes the core; enables play no part
			wake_req <= |(next_flag & ~irq_flag);
			// Pull-high follows its selection even when the pin is the interrupt input
			pull_high_en <= pullup_sel;
		end
	end

	// Configuration registers
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			prescaler_src_sel <= `PIST_PSC_RST;
			tb0_run <= 1'b0;
			tb0_period_sel <= 3'h0;
			tb1_run <= 1'b0;
			tb1_period_sel <= 3'h0;
			edge_select_reg <= `PIST_EDGE_RST;
		end else if (clk_en && wr_fire) begin
			case (paddr)
				`PIST_ADDR_PSC: begin
					prescaler_src_sel <= pwdata[`PIST_PSC_SEL_MSB:`PIST_PSC_SEL_LSB];
				end
				`PIST_ADDR_TB0C: begin
					tb0_run <= pwdata[`PIST_TBC_RUN];
					tb0_period_sel <= pwdata[`PIST_TBC_PER_MSB:`PIST_TBC_PER_LSB];
				end
				`PIST_ADDR_TB1C: begin
					tb1_run <= pwdata[`PIST_TBC_RUN];
					tb1_period_sel <= pwdata[`PIST_TBC_PER_MSB:`PIST_TBC_PER_LSB];
				end
				`PIST_ADDR_EDGE: begin
					edge_select_reg <= pwdata[1:0];
				end
				default: begin
					edge_select_reg <= edge_select_reg;
				end
			endcase
		end
	end

	// Read mux; unused bits read zero, unmapped addresses answer with an error
	always @* begin
		rd_data = 32'h0000_0000;
		rd_err = 1'b0;
		case (paddr)
			`PIST_ADDR_PSC: rd_data[1:0] = prescaler_src_sel;
			`PIST_ADDR_TB0C: begin
				rd_data[`PIST_TBC_RUN] = tb0_run;
				rd_data[2:0] = tb0_period_sel;
			end
			`PIST_ADDR_TB1C: begin
				rd_data[`PIST_TBC_RUN] = tb1_run;
				rd_data[2:0] = tb1_period_sel;
			end
			`PIST_ADDR_IEN: rd_data[5:0] = irq_enable;
			`PIST_ADDR_IFLAG: rd_data[4:0] = irq_flag;
			`PIST_ADDR_EDGE: rd_data[1:0] = edge_select_reg;
			`PIST_ADDR_STAT: begin
				rd_data[0] = irq_req;
				rd_data[3:1] = irq_vector;
				rd_data[4] = pin_sync;
				rd_data[5] = stack_full;
			end
			default: rd_err = 1'b1;
		endcase
	end

	// APB answer prepared in the setup cycle, so every access is zero-wait
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			if (setup) begin
				pready <= 1'b1;
				pslverr <= rd_err;
				prdata <= pwrite ? 32'h0000_0000 : rd_data;
			end else begin
				pready <= 1'b0;
				pslverr <= 1'b0;
			end
		end
	end

endmodule
`default_nettype wire

// ### common/pist_regs.vh
// Register map, field positions, reset values and codes of the interrupt source block
`ifndef PIST_REGS_VH
`define PIST_REGS_VH

// Register byte addresses (12-bit APB address)
`define PIST_ADDR_PSC 12'h000
`define PIST_ADDR_TB0C 12'h004
`define PIST_ADDR_TB1C 12'h008
`define PIST_ADDR_IEN 12'h00c
`define PIST_ADDR_IFLAG 12'h010
`define PIST_ADDR_EDGE 12'h014
`define PIST_ADDR_STAT 12'h018

// Prescaler source field
`define PIST_PSC_SEL_MSB 1
`define PIST_PSC_SEL_LSB 0
`define PIST_PSC_SYS 2'h0
`define PIST_PSC_SYS_DIV4 2'h1
`define PIST_PSC_RST 2'h0

// Time-base unit control fields
`define PIST_TBC_RUN 7
`define PIST_TBC_PER_MSB 2
`define PIST_TBC_PER_LSB 0
`define PIST_TBC_RST 4'h0
`define PIST_TB_MIN_PERIOD 16'h0100

// Enable register bits
`define PIST_IEN_GLOBAL 0
`define PIST_IEN_EXT 1
`define PIST_IEN_CONV 2
`define PIST_IEN_TB0 3
`define PIST_IEN_TB1 4
`define PIST_IEN_SER 5
`define PIST_IEN_RST 6'h00

// Flag register bits, also the source index
`define PIST_SRC_EXT 0
`define PIST_SRC_CONV 1
`define PIST_SRC_TB0 2
`define PIST_SRC_TB1 3
`define PIST_SRC_SER 4
`define PIST_NUM_SRC 5
`define PIST_IFLAG_RST 5'h00

// Edge select codes
`define PIST_EDGE_OFF 2'h0
`define PIST_EDGE_RISE 2'h1
`define PIST_EDGE_FALL 2'h2
`define PIST_EDGE_BOTH 2'h3
`define PIST_EDGE_RST 2'h0

// Vector codes presented to the core
`define PIST_VEC_EXT 3'h0
`define PIST_VEC_CONV 3'h1
`define PIST_VEC_TB0 3'h2
`define PIST_VEC_TB1 3'h3
`define PIST_VEC_SER 3'h4

// Divide-by-four prescaler terminal count
`define PIST_DIV4_LAST 2'h3

`endif

// ### core/pist_tbu.v
// Time-base unit: period divider clocked by prescaler ticks, one overflow pulse per period
`timescale 1ns/100ps
`default_nettype none
`include "pist_regs.vh"

module pist_tbu (
	// Clock and reset
	input wire sys_clk,
	input wire sys_rst,
	input wire clk_en,
	// Control
	input wire tick,
	input wire run,
	input wire [2:0] period_sel,
	// Event
	output reg overflow
);

	reg [15:0] count;
	wire [15:0] last;

	// Terminal count is 2^(8+sel) ticks minus one
	assign last = (`PIST_TB_MIN_PERIOD << period_sel) - 16'h0001;

	// Divider chain; held at zero while the unit is off so a restart gives a full period
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			count <= 16'h0000;
			overflow <= 1'b0;
		end else if (clk_en) begin
			overflow <= 1'b0;
			if (!run) begin
				count <= 16'h0000;
			end else if (tick) begin
				if (count >= last) begin
					count <= 16'h0000;
					overflow <= 1'b1;
				end else begin
					count <= count + 16'h0001;
				end
			end
		end
	end

endmodule
`default_nettype wire

// ### testbench/pist_ctrl_chk.sv
// Port checker for the interrupt source block
`timescale 1ns/100ps
`default_nettype none
`include "pist_regs.vh"
module pist_ctrl_chk (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// Bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// Pin
	input wire logic pullup_sel,
	input wire logic pull_high_en,
	// Core
	input wire logic stack_full,
	input wire logic irq_ack,
	input wire logic return_from_irq,
	input wire logic irq_req,
	input wire logic [2:0] irq_vector
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// Service taken, then a cycle with nothing that could re-enable
	sequence s_service; clk_en && irq_req && irq_ack; endsequence
	sequence s_quiet; clk_en && !return_from_irq && !psel; endsequence
	property p_ack_clear; s_service |=> !irq_req; endproperty
	a_ack_clear: assert property (p_ack_clear) else $error("request kept after service");
	property p_ret_needed; s_service ##1 s_quiet |=> !irq_req; endproperty
	a_ret_needed: assert property (p_ret_needed) else $error("request before return");
	property p_stack; clk_en && stack_full |=> !irq_req; endproperty
	a_stack: assert property (p_stack) else $error("request with full stack");
	property p_pull; clk_en |=> pull_high_en == $past(pullup_sel); endproperty
	a_pull: assert property (p_pull) else $error("pull-high not following selection");
	property p_freeze; !clk_en |=> $stable(irq_req) && $stable(irq_vector); endproperty
	a_freeze: assert property (p_freeze) else $error("request moved while frozen");
	property p_vec; irq_req |-> irq_vector <= `PIST_VEC_SER; endproperty
	a_vec: assert property (p_vec) else $error("vector out of range");
	property p_answer; clk_en && psel && !penable |=> pready; endproperty
	a_answer: assert property (p_answer) else $error("register access not answered");
	property p_once; clk_en && pready |=> !pready; endproperty
	a_once: assert property (p_once) else $error("answer held too long");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("error without answer");
endmodule
`default_nettype wire

// ### testbench/pist_core_model.sv
// Core model: takes requests after a set delay, returns three cycles later
`timescale 1ns/100ps
`default_nettype none
module pist_core_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Bench control
	input wire logic auto_srv,
	input wire logic [3:0] ack_dly,
	// Request
	input wire logic irq_req,
	input wire logic [2:0] irq_vector,
	// Service
	output logic irq_ack,
	output logic return_from_irq,
	output logic [2:0] last_vec,
	output logic [7:0] serves
);
	logic [3:0] wait_cnt;
	logic [1:0] ret_cnt;
	// A slow delay lets a higher source overtake a pending one
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_ack <= 1'h0;
			return_from_irq <= 1'h0;
			last_vec <= 3'h0;
			serves <= 8'h00;
			wait_cnt <= 4'h0;
			ret_cnt <= 2'h0;
		end else begin
			irq_ack <= 1'h0;
			return_from_irq <= (ret_cnt == 2'h1);
			if (irq_ack && irq_req) begin
				last_vec <= irq_vector;
				serves <= serves + 8'h01;
			end
			if (ret_cnt != 2'h0) begin
				ret_cnt <= ret_cnt - 2'h1;
			end else if (auto_srv && irq_req && !irq_ack) begin
				wait_cnt <= wait_cnt + 4'h1;
				if (wait_cnt == ack_dly) begin
					irq_ack <= 1'h1;
					wait_cnt <= 4'h0;
					ret_cnt <= 2'h3;
				end
			end else begin
				wait_cnt <= 4'h0;
			end
		end
	end
endmodule
`default_nettype wire

// ### testbench/pist_bench.sv
// Testbench for the interrupt source block
`timescale 1ns/100ps
`default_nettype none
`include "pist_regs.vh"
module pist_bench;
	logic sys_clk = 1'h0;
	logic sys_rst = 1'h1;
	logic clk_en = 1'h1;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, q;
	logic pready, pslverr, pull_high_en, irq_req, wake_req, irq_ack, return_from_irq, err;
	logic ext_pin = 1'h0;
	logic func_sel = 1'h0;
	logic pin_in = 1'h0;
	logic pullup_sel = 1'h0;
	logic sub_tick = 1'h0;
	logic uart_mode = 1'h0;
	logic stack_full = 1'h0;
	logic auto_srv = 1'h0;
	logic [9:0] ev = 10'h000;
	logic [3:0] ack_dly = 4'h0;
	logic [2:0] irq_vector, last_vec;
	logic [7:0] serves, s0;
	logic [1:0] sub_div = 2'h0;
	logic [2:0] order [3] = '{3'h0, 3'h1, 3'h4};
	logic tb_unit [5] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h1};
	logic [1:0] tb_psc [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
	logic [2:0] tb_sel [5] = '{3'h0, 3'h1, 3'h0, 3'h2, 3'h0};
	logic [31:0] tb_per [5] = '{32'h0000_0100, 32'h0000_0800, 32'h0000_0300, 32'h0000_0c00,
		32'h0000_0100};
	int num_errors = 0;
	int check_count = 0;
	int wakes = 0;
	int w0;
	time t0, t1;
	always #5 sys_clk = ~sys_clk;
	// Sub clock tick every third cycle
	always @(posedge sys_clk) begin
		sub_div <= (sub_div == 2'h2) ? 2'h0 : sub_div + 2'h1;
		sub_tick <= (sub_div == 2'h2);
	end
	// Wake pulses counted here, compared later
	always @(posedge sys_clk) if (wake_req === 1'h1) wakes <= wakes + 1;
	pist_ctrl pist_ctrl_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ext_irq_pin(ext_pin), .pin_func_sel(func_sel),
		.port_is_input(pin_in), .pullup_sel(pullup_sel), .pull_high_en(pull_high_en),
		.conv_done(ev[0]), .sub_clk_tick(sub_tick), .serial_uart_mode(uart_mode),
		.spi_i2c_byte_done(ev[1]), .i2c_addr_match(ev[2]), .i2c_bus_timeout(ev[3]),
		.uart_tx_empty(ev[4]), .uart_tx_idle(ev[5]), .uart_rx_avail(ev[6]),
		.uart_rx_overrun(ev[7]), .uart_addr_detect(ev[8]), .uart_rx_wake(ev[9]),
		.stack_full(stack_full), .irq_ack(irq_ack), .return_from_irq(return_from_irq),
		.irq_req(irq_req), .irq_vector(irq_vector), .wake_req(wake_req));
	pist_core_model pist_core_model_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .auto_srv(auto_srv),
		.ack_dly(ack_dly), .irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(irq_ack),
		.return_from_irq(return_from_irq), .last_vec(last_vec), .serves(serves));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One APB transfer; the request stands until pready is sampled high
	task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'h1;
		penable <= 1'h0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'h1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'h1);
		q = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(a, 1'h1, d);
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		xfer(a, 1'h0, 32'h0000_0000);
		check(q, exp);
	endtask
	task automatic pulse(input int i);
		@(posedge sys_clk);
		ev[i] <= 1'h1;
		@(posedge sys_clk);
		ev[i] <= 1'h0;
	endtask
	// Time of the next rising edge of the request
	task automatic wait_rise(output time t);
		logic prev;
		int n;
		prev = 1'h1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
			if (irq_req === 1'h1 && prev === 1'h0) break;
			prev = irq_req;
		end while (n < 9000);
		t = $time;
	endtask
	task automatic complete_run;
		$display("Checks %0d, mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Watchdog well beyond the expected run
	initial begin
		repeat (60000) @(posedge sys_clk);
		num_errors++;
		complete_run;
	end
	initial begin
		repeat (16) @(posedge sys_clk);
		sys_rst <= 1'h0;
		rd_chk(`PIST_ADDR_TB0C, 32'h0000_0000);
		wr(`PIST_ADDR_PSC, 32'hffff_ffff);
		rd_chk(`PIST_ADDR_PSC, 32'h0000_0003);
		wr(`PIST_ADDR_TB0C, 32'hffff_ffff);
		rd_chk(`PIST_ADDR_TB0C, 32'h0000_0087);
		wr(`PIST_ADDR_TB0C, 32'h0000_0000);
		xfer(12'h01c, 1'h0, 32'h0000_0000);
		check({q[30:0], err}, 32'h0000_0001);
		// Short freeze, then pull-high follows its selection
		pullup_sel <= 1'h1;
		clk_en <= 1'h0;
		repeat (4) @(posedge sys_clk);
		clk_en <= 1'h1;
		repeat (2) @(posedge sys_clk);
		check({31'h0, pull_high_en}, 32'h0000_0001);
		func_sel <= 1'h1;
		pin_in <= 1'h1;
		w0 = wakes;
		// Every edge code against a rising and a falling pin
		for (int c = 0; c < 4; c++) begin
			wr(`PIST_ADDR_EDGE, 32'(c));
			for (int r = 0; r < 2; r++) begin
				@(posedge sys_clk);
				ext_pin <= ~ext_pin;
				repeat (6) @(posedge sys_clk);
				rd_chk(`PIST_ADDR_IFLAG, {31'h0, c[r]});
				wr(`PIST_ADDR_IFLAG, 32'h0000_0000);
			end
		end
		check(32'(wakes - w0), 32'h0000_0004);
		// Three sources wait behind a full stack, then drain by priority
		wr(`PIST_ADDR_IEN, 32'h0000_003f);
		stack_full <= 1'h1;
		ack_dly <= 4'h9;
		auto_srv <= 1'h1;
		uart_mode <= 1'h1;
		ext_pin <= 1'h1;
		pulse(0);
		pulse(4);
		repeat (4) @(posedge sys_clk);
		check({31'h0, irq_req}, 32'h0000_0000);
		rd_chk(`PIST_ADDR_IFLAG, 32'h0000_0013);
		rd_chk(`PIST_ADDR_STAT, 32'h0000_0030);
		s0 = serves;
		stack_full <= 1'h0;
		for (int i = 0; i < 3; i++) begin
			for (int k = 0; k < 200 && serves != s0 + 8'(i + 1); k++) @(posedge sys_clk);
			check({24'h0, serves}, {24'h0, s0 + 8'(i + 1)});
			check({29'h0, last_vec}, {29'h0, order[i]});
		end
		repeat (10) @(posedge sys_clk);
		rd_chk(`PIST_ADDR_IFLAG, 32'h0000_0000);
		rd_chk(`PIST_ADDR_IEN, 32'h0000_003f);
		// Each serial event in its own mode sets the serial flag
		auto_srv <= 1'h0;
		wr(`PIST_ADDR_IEN, 32'h0000_0000);
		for (int i = 1; i < 10; i++) begin
			uart_mode <= (i > 3);
			pulse(i);
			@(posedge sys_clk);
			rd_chk(`PIST_ADDR_IFLAG, 32'h0000_0010);
			wr(`PIST_ADDR_IFLAG, 32'h0000_0000);
		end
		// A UART event is ignored while the module is in SPI/I2C mode
		uart_mode <= 1'h0;
		pulse(4);
		@(posedge sys_clk);
		rd_chk(`PIST_ADDR_IFLAG, 32'h0000_0000);
		// Time-base periods per source and period code, serviced by a prompt core
		auto_srv <= 1'h1;
		ack_dly <= 4'h0;
		for (int e = 0; e < 5; e++) begin
			wr(`PIST_ADDR_PSC, {30'h0, tb_psc[e]});
			wr(`PIST_ADDR_IEN, tb_unit[e] ? 32'h0000_0011 : 32'h0000_0009);
			wr(tb_unit[e] ? `PIST_ADDR_TB1C : `PIST_ADDR_TB0C, {24'h0, 5'h10, tb_sel[e]});
			wait_rise(t0);
			wait_rise(t0);
			wait_rise(t1);
			check(32'((t1 - t0) / 10), tb_per[e]);
			repeat (4) @(posedge sys_clk);
			check({29'h0, last_vec}, tb_unit[e] ? 32'h0000_0003 : 32'h0000_0002);
			wr(tb_unit[e] ? `PIST_ADDR_TB1C : `PIST_ADDR_TB0C, 32'h0000_0000);
		end
		s0 = serves;
		repeat (600) @(posedge sys_clk);
		check({24'h0, serves}, {24'h0, s0});
		complete_run;
	end
endmodule
bind pist_ctrl pist_ctrl_chk pist_ctrl_chk_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
	.clk_en(clk_en), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
	.pullup_sel(pullup_sel), .pull_high_en(pull_high_en), .stack_full(stack_full),
	.irq_ack(irq_ack), .return_from_irq(return_from_irq), .irq_req(irq_req),
	.irq_vector(irq_vector));
`default_nettype wire
